// >>> src/sar_adc_sequencer.sv
`timescale 1ns/10ps
module sar_adc_sequencer
  import sadc_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic clkEn,
  input wire logic oscillatorClockTick,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic compareHigh,
  output sadc_analog_t analogCtrl,
  output logic convBusy,
  output logic convIrq,
  input wire logic [NUM_CHANNELS-1:0] pinIn,
  output logic [NUM_CHANNELS-1:0] pinOut,
  output logic [NUM_CHANNELS-1:0] pinOe
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // one-hot of the pin owned by the converter, none when off or unused
  function automatic logic [NUM_CHANNELS-1:0] chanOneHot(input logic [4:0] ch);
    logic [NUM_CHANNELS-1:0] oh;
    oh = '0;
    if (ch <= CHAN_LAST) begin
      oh[ch[3:0]] = 1'b1;
    end
    return oh;
  endfunction

  function automatic sadc_result_t formatResult(input logic [9:0] r, input sadc_fmt_t f);
    sadc_result_t o;
    o = '0;
    unique case (f)
      SADC_FMT_LEFT: begin
        o.high = r[9:2];
        o.low = {r[1:0], 6'h00};
      end
      SADC_FMT_RIGHT: begin
        o.high = {6'h00, r[9:8]};
        o.low = r[7:0];
      end
      SADC_FMT_SIGNED: begin
        o.high = {~r[9], r[8:2]};
        o.low = {r[1:0], 6'h00};
      end
      SADC_FMT_TRUNC8: begin
        o.high = 8'h00;
        o.low = r[9:2];
      end
    endcase
    return o;
  endfunction

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic irqEnable;
  logic contConv;
  logic [4:0] channelSelect;
  logic completeFlag;
  logic [7:0] clockCtrl;
  sadc_result_t result;
  logic highReadPending;
  logic [NUM_CHANNELS-1:0] portData;
  logic [NUM_CHANNELS-1:0] portDir;
  sadc_state_t state;
  logic [7:0] divCount;
  logic [3:0] stepCount;
  logic [9:0] sarCode;
  logic [9:0] sarTrial;
  logic convTick;
  logic statusWrite;
  logic dataRead;
  logic highRead;
  logic convDone;
  logic [NUM_CHANNELS-1:0] owned;
  logic converterOn;
  logic wrFire;
  logic rdFire;
  logic [7:0] wrAddr;
  logic [7:0] wrByte;
  logic [1:0] wrResp;
  logic haveAw;
  logic haveW;
  logic [7:0] awHeld;
  logic [7:0] wHeld;
  sadc_fmt_t fmtSel;

  assign fmtSel = sadc_fmt_t'(clockCtrl[CK_FMT_LSB +: 2]);
  assign converterOn = (channelSelect != CHAN_OFF);
  assign owned = chanOneHot(channelSelect);

  // ---------------------------------------------------------------
  // axi4-lite write path
  // ---------------------------------------------------------------
  // address and data are taken independently and joined here
  assign s_axi_awready = clkEn && !haveAw && !s_axi_bvalid;
  assign s_axi_wready = clkEn && !haveW && !s_axi_bvalid;
  assign wrAddr = haveAw ? awHeld : s_axi_awaddr;
  assign wrByte = haveW ? wHeld : s_axi_wdata[7:0];
  assign wrFire = clkEn && !s_axi_bvalid && (haveAw || s_axi_awvalid)
    && (haveW || s_axi_wvalid);

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      haveAw <= 1'b0;
      haveW <= 1'b0;
      awHeld <= 8'h00;
      wHeld <= 8'h00;
    end else if (clkEn) begin
      if (wrFire) begin
        haveAw <= 1'b0;
        haveW <= 1'b0;
      end else begin
        if (s_axi_awvalid && s_axi_awready) begin
          haveAw <= 1'b1;
          awHeld <= s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
          haveW <= 1'b1;
          wHeld <= s_axi_wdata[7:0];
        end
      end
    end
  end

  // a lane-0 strobe is needed; unmapped addresses answer slverr
  always_comb begin
    wrResp = RESP_OKAY;
    unique case (wrAddr)
      ADDR_STATUS_CTRL, ADDR_CLOCK_CTRL, ADDR_PORT_DATA, ADDR_PORT_DIR: wrResp = RESP_OKAY;
      ADDR_RESULT_HIGH, ADDR_RESULT_LOW, ADDR_PORT_PINS: wrResp = RESP_OKAY;
      default: wrResp = RESP_SLVERR;
    endcase
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (clkEn) begin
      if (wrFire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wrResp;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // strobe lane 0 gates every store; wrLaneHeld holds lane 0 of wstrb beside wHeld
  logic wrLane;
  logic wrLaneHeld;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      wrLaneHeld <= 1'b0;
    end else if (clkEn && s_axi_wvalid && s_axi_wready) begin
      wrLaneHeld <= s_axi_wstrb[0];
    end
  end
  assign wrLane = haveW ? wrLaneHeld : s_axi_wstrb[0];
  assign statusWrite = wrFire && wrLane && (wrAddr == ADDR_STATUS_CTRL);

  // ---------------------------------------------------------------
  // axi4-lite read path
  // ---------------------------------------------------------------
  assign s_axi_arready = clkEn && !s_axi_rvalid;
  assign rdFire = s_axi_arvalid && s_axi_arready;
  assign highRead = rdFire && (s_axi_araddr == ADDR_RESULT_HIGH);
  assign dataRead = rdFire && (s_axi_araddr == ADDR_RESULT_LOW);

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (clkEn) begin
      if (rdFire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= RESP_OKAY;
        unique case (s_axi_araddr)
          ADDR_STATUS_CTRL: s_axi_rdata <= {24'h000000, completeFlag && !irqEnable,
            irqEnable, contConv, channelSelect};
          ADDR_RESULT_HIGH: s_axi_rdata <= {24'h000000, result.high};
          ADDR_RESULT_LOW: s_axi_rdata <= {24'h000000, result.low};
          ADDR_CLOCK_CTRL: s_axi_rdata <= {24'h000000, clockCtrl};
          ADDR_PORT_DATA: s_axi_rdata <= {22'h000000, portData};
          ADDR_PORT_DIR: s_axi_rdata <= {22'h000000, portDir};
          ADDR_PORT_PINS: s_axi_rdata <= {22'h000000, pinIn & ~owned};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      irqEnable <= 1'b0;
      contConv <= 1'b0;
      channelSelect <= CHAN_RESET;
      clockCtrl <= CLOCK_CTRL_RESET;
    end else if (clkEn && wrFire && wrLane) begin
      if (wrAddr == ADDR_STATUS_CTRL) begin
        irqEnable <= wrByte[SC_IRQ_EN_BIT];
        contConv <= wrByte[SC_CONT_BIT];
        channelSelect <= wrByte[4:0];
      end
      if (wrAddr == ADDR_CLOCK_CTRL) begin
        clockCtrl <= wrByte;
      end
    end
  end

  // port latches drop writes to the owned pin's bit, and the pads mask that pin as well
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      portData <= '0;
      portDir <= '0;
    end else if (clkEn && wrFire && wrLane) begin
      if (wrAddr == ADDR_PORT_DATA) begin
        portData <= (NUM_CHANNELS'(wrByte) & ~owned) | (portData & owned);
      end
      if (wrAddr == ADDR_PORT_DIR) begin
        portDir <= (NUM_CHANNELS'(wrByte) & ~owned) | (portDir & owned);
      end
    end
  end

  // the 8-bit byte has only 8 lanes; a write clears bits 9:8 of the port latches unless owned
  assign pinOut = portData & ~owned;
  assign pinOe = portDir & ~owned;

  // ---------------------------------------------------------------
  // converter clock: source select then prescale
  // ---------------------------------------------------------------
  // divider counts source ticks; ratio 2^div, kept as tick pulses on mclk
  logic srcTick;
  logic [7:0] divLimit;
  assign srcTick = clockCtrl[CK_SRC_BIT] ? oscillatorClockTick : 1'b1;
  assign divLimit = 8'((9'h001 << clockCtrl[CK_DIV_LSB +: 3]) - 9'h001);
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      divCount <= 8'h00;
      convTick <= 1'b0;
    end else if (clkEn) begin
      convTick <= 1'b0;
      if (srcTick) begin
        if (divCount >= divLimit) begin
          divCount <= 8'h00;
          convTick <= 1'b1;
        end else begin
          divCount <= divCount + 8'h01;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // sequencer: align, settle, ten sar steps
  // ---------------------------------------------------------------
  // align ends the partial tick, then six settle and ten bit ticks give
  // sixteen whole ticks; a continuous restart skips align, still sixteen
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state <= SADC_IDLE;
      stepCount <= 4'h0;
      sarCode <= 10'h000;
    end else if (clkEn) begin
      if (statusWrite) begin
        state <= (wrByte[4:0] != CHAN_OFF) ? SADC_ALIGN : SADC_IDLE;
        stepCount <= 4'h0;
        sarCode <= 10'h000;
      end else if (!converterOn) begin
        state <= SADC_IDLE;
      end else if (convTick) begin
        unique case (state)
          SADC_IDLE: state <= SADC_IDLE;
          SADC_ALIGN: begin
            state <= SADC_SETTLE;
            stepCount <= 4'h0;
          end
          SADC_SETTLE: begin
            if (stepCount == SETTLE_CYCLES - 4'h1) begin
              state <= SADC_SAR;
              stepCount <= 4'h0;
            end else begin
              stepCount <= stepCount + 4'h1;
            end
          end
          SADC_SAR: begin
            sarCode <= compareHigh ? sarTrial : sarCode;
            if (stepCount == SAR_STEPS) begin
              state <= contConv ? SADC_SETTLE : SADC_IDLE;
              stepCount <= 4'h0;
              sarCode <= 10'h000; // a restart must not inherit old bits
            end else begin
              stepCount <= stepCount + 4'h1;
            end
          end
        endcase
      end
    end
  end

  // trial adds the bit under test, msb first
  assign sarTrial = sarCode | (10'h200 >> stepCount);
  assign convDone = convTick && converterOn && !statusWrite && (state == SADC_SAR)
    && (stepCount == SAR_STEPS);
  assign convBusy = (state != SADC_IDLE);
  assign analogCtrl = '{powerOn: converterOn, channel: channelSelect, trialCode: sarTrial};

  // ---------------------------------------------------------------
  // result store, interlock, completion
  // ---------------------------------------------------------------
  // high read arms the interlock except in SADC_FMT_TRUNC8, which keeps it clear; low read frees it, set wins over clear
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      highReadPending <= 1'b0;
    end else if (clkEn) begin
      if (highRead && fmtSel != SADC_FMT_TRUNC8) begin
        highReadPending <= 1'b1;
      end else if (dataRead || fmtSel == SADC_FMT_TRUNC8) begin
        highReadPending <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      result <= '0;
    end else if (clkEn && convDone && !highReadPending) begin
      result <= formatResult(compareHigh ? sarTrial : sarCode, fmtSel);
    end
  end

  // end of conversion sets, data read clears; set wins in a tie
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      completeFlag <= 1'b0;
    end else if (clkEn) begin
      if (convDone && !highReadPending) begin
        completeFlag <= 1'b1;
      end else if (dataRead || statusWrite) begin
        completeFlag <= 1'b0;
      end
    end
  end

  assign convIrq = completeFlag && irqEnable;

endmodule

// >>> pkg/sadc_pkg.sv
package sadc_pkg;
  // ---------------------------------------------------------------
  // register map (byte addresses, one aligned word each)
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_STATUS_CTRL = 8'h00;
  localparam logic [7:0] ADDR_RESULT_HIGH = 8'h04;
  localparam logic [7:0] ADDR_RESULT_LOW = 8'h08;
  localparam logic [7:0] ADDR_CLOCK_CTRL = 8'h0c;
  localparam logic [7:0] ADDR_PORT_DATA = 8'h10;
  localparam logic [7:0] ADDR_PORT_DIR = 8'h14;
  localparam logic [7:0] ADDR_PORT_PINS = 8'h18;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int SC_COMPLETE_BIT = 7;
  localparam int SC_IRQ_EN_BIT = 6;
  localparam int SC_CONT_BIT = 5;
  localparam int CK_SRC_BIT = 4;
  localparam int CK_FMT_LSB = 2;
  localparam int CK_DIV_LSB = 5;

  // ---------------------------------------------------------------
  // sizes and values
  // ---------------------------------------------------------------
  localparam int NUM_CHANNELS = 10;
  localparam int RESULT_BITS = 10;
  localparam logic [4:0] CHAN_OFF = 5'h1f;
  localparam logic [4:0] CHAN_LAST = 5'h09;
  localparam logic [4:0] CHAN_RESET = 5'h1f;
  localparam logic [3:0] SAR_STEPS = 4'h9;
  localparam logic [3:0] SETTLE_CYCLES = 4'h6;
  localparam logic [7:0] CLOCK_CTRL_RESET = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    SADC_FMT_LEFT,
    SADC_FMT_RIGHT,
    SADC_FMT_SIGNED,
    SADC_FMT_TRUNC8
  } sadc_fmt_t;

  typedef enum logic [1:0] {
    SADC_IDLE,
    SADC_ALIGN,
    SADC_SETTLE,
    SADC_SAR
  } sadc_state_t;

  // formatted result pair, stored in one edge
  typedef struct packed {
    logic [7:0] high;
    logic [7:0] low;
  } sadc_result_t;

  // analog side request: channel, trial code, power
  typedef struct packed {
    logic powerOn;
    logic [4:0] channel;
    logic [9:0] trialCode;
  } sadc_analog_t;
endpackage

// >>> testbench/sadc_props.sv
`timescale 1ns/10ps
// ---------------------------------------------------------------
// port checker
// ---------------------------------------------------------------
module sadc_props
  import sadc_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input sadc_analog_t analogCtrl,
  input wire logic convBusy,
  input wire logic convIrq,
  input wire logic [NUM_CHANNELS-1:0] pinOut,
  input wire logic [NUM_CHANNELS-1:0] pinOe
);
  logic wrJoin;
  logic rdTake;
  logic owned;
  // joined write, accepted read, pin held by the converter
  assign wrJoin = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  assign rdTake = s_axi_arvalid && s_axi_arready;
  assign owned = analogCtrl.powerOn && (analogCtrl.channel <= CHAN_LAST);

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  AST_WR_ANSWER: assert property (wrJoin |=> s_axi_bvalid)
    else $error("write response missing");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  AST_RD_ANSWER: assert property (rdTake |=> s_axi_rvalid)
    else $error("read response missing");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data moved while stalled");
  AST_BAD_ADDR: assert property (rdTake && s_axi_araddr > ADDR_PORT_PINS |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  AST_OWN_PIN: assert property (owned |-> !pinOe[analogCtrl.channel[3:0]] && !pinOut[analogCtrl.channel[3:0]])
    else $error("converter pin still driven");
  AST_PIN_READ: assert property (rdTake && s_axi_araddr == ADDR_PORT_PINS && owned |=> !s_axi_rdata[$past(analogCtrl.channel[3:0])])
    else $error("owned pin reads one");
  AST_OFF: assert property (analogCtrl.channel == CHAN_OFF |-> !analogCtrl.powerOn && !convBusy)
    else $error("converter on while switched off");
  AST_WR_IRQ: assert property (wrJoin && s_axi_awaddr == ADDR_STATUS_CTRL |=> !convIrq [*2])
    else $error("irq kept after status write");
  AST_RD_IRQ: assert property (rdTake && s_axi_araddr == ADDR_RESULT_LOW |=> !convIrq)
    else $error("irq kept after data read");
  AST_IRQ_FLAG: assert property (convIrq && rdTake && s_axi_araddr == ADDR_STATUS_CTRL |=> !s_axi_rdata[SC_COMPLETE_BIT])
    else $error("flag visible with irq enabled");
endmodule

bind sar_adc_sequencer sadc_props u_props (
  .mclk(mclk), .resetn(resetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .analogCtrl(analogCtrl), .convBusy(convBusy),
  .convIrq(convIrq), .pinOut(pinOut), .pinOe(pinOe)
);

// >>> testbench/sadc_analog_model.sv
`timescale 1ns/10ps
// ---------------------------------------------------------------
// analog mux and comparator
// ---------------------------------------------------------------
module sadc_analog_model
  import sadc_pkg::*;
(
  input wire logic mclk,
  input sadc_analog_t analogCtrl,
  input wire logic [NUM_CHANNELS-1:0][9:0] levels,
  output logic compareHigh
);
  logic lastCmp = 1'b0;
  logic [9:0] chosen;
  // ten pins in order; internal channels sit at the low reference
  always_comb begin
    chosen = 10'h000;
    if (analogCtrl.channel <= CHAN_LAST) chosen = levels[analogCtrl.channel[3:0]];
  end
  // powered down the output wanders, so a stale level is never trusted
  always_comb begin
    if (analogCtrl.powerOn) compareHigh = (chosen >= analogCtrl.trialCode);
    else compareHigh = ~lastCmp;
  end
  always @(posedge mclk) lastCmp <= compareHigh;
endmodule

// >>> testbench/tb_sar_adc_sequencer.sv
`timescale 1ns/10ps
module tb_sar_adc_sequencer
  import sadc_pkg::*;
;
  logic mclk = 0, resetn = 0, clkEn = 1, oscTick = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0;
  logic [3:0] s_axi_wstrb = 4'h1;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic compareHigh, convBusy, convIrq;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [31:0] s_axi_rdata, rd;
  sadc_analog_t analogCtrl;
  logic [9:0] pinOut, pinOe;
  logic [9:0] pinIn = 10'h3ff;
  logic [NUM_CHANNELS-1:0][9:0] levels = '0;
  logic [15:0] ex;
  logic [7:0] ckv [4] = '{8'h00, 8'h44, 8'h38, 8'h0c};
  logic [9:0] lv [4] = '{10'h2d6, 10'h3ff, 10'h000, 10'h15b};
  int per [4] = '{1, 4, 6, 1};
  int failures = 0, compares = 0, run = 0, lastRun = 0, oscCnt = 0;

  sar_adc_sequencer u_dut (
    .mclk(mclk), .resetn(resetn), .clkEn(clkEn), .oscillatorClockTick(oscTick),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .compareHigh(compareHigh),
    .analogCtrl(analogCtrl), .convBusy(convBusy), .convIrq(convIrq), .pinIn(pinIn),
    .pinOut(pinOut), .pinOe(pinOe)
  );
  sadc_analog_model u_analog (
    .mclk(mclk), .analogCtrl(analogCtrl), .levels(levels), .compareHigh(compareHigh)
  );

  // ---------------------------------------------------------------
  // clock, oscillator ticks, busy span
  // ---------------------------------------------------------------
  initial forever #4 mclk = ~mclk;
  // a tick every third cycle keeps the oscillator unrelated to the prescale
  always @(posedge mclk) begin
    oscCnt <= (oscCnt == 2) ? 0 : oscCnt + 1;
    oscTick <= (oscCnt == 2);
  end
  always @(posedge mclk) begin
    if (convBusy === 1'b1) run <= run + 1;
    else begin
      if (run != 0) lastRun <= run;
      run <= 0;
    end
  end

  // ---------------------------------------------------------------
  // bus tasks
  // ---------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // response ready held low for one cycle so the slave must wait
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bit ta = 0;
    bit tw = 0;
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= {24'h0, d};
    s_axi_wvalid <= 1'b1;
    while (!(ta && tw)) begin
      @(posedge mclk);
      if (!ta && s_axi_awready === 1'b1) begin ta = 1; s_axi_awvalid <= 1'b0; end
      if (!tw && s_axi_wready === 1'b1) begin tw = 1; s_axi_wvalid <= 1'b0; end
    end
    do @(posedge mclk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b1;
    do @(posedge mclk); while (s_axi_bvalid !== 1'b1);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rdr(input logic [7:0] a);
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge mclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge mclk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b1;
    do @(posedge mclk); while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic wait_flag();
    for (int n = 0; n < 60; n++) begin
      rdr(ADDR_STATUS_CTRL);
      if (rd[SC_COMPLETE_BIT] === 1'b1) break;
    end
  endtask
  // expected {high, low} for each format
  function automatic logic [15:0] fmt_exp(input int f, input logic [9:0] c);
    case (f)
      0: return {c[9:2], c[1:0], 6'h0};
      1: return {6'h0, c[9:8], c[7:0]};
      2: return {~c[9], c[8:2], c[1:0], 6'h0};
      default: return {8'h0, c[9:2]};
    endcase
  endfunction
  task close_out();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    repeat (8) @(posedge mclk);
    resetn <= 1'b1;
    rdr(ADDR_STATUS_CTRL); chk("status reset", 32'h1f, {24'h0, rd[7:0]});
    rdr(ADDR_CLOCK_CTRL); chk("clock reset", 32'h0, {24'h0, rd[7:0]});
    rdr(8'h1c); chk("unmapped resp", RESP_SLVERR, rsp);
    wr(8'h1c, 8'h00); chk("unmapped write", RESP_SLVERR, rsp);
    // each format in turn; the oscillator only for signed, a prescale only for right and signed
    for (int i = 0; i < 4; i++) begin
      levels[3] = lv[i];
      ex = fmt_exp(i, lv[i]);
      wr(ADDR_CLOCK_CTRL, ckv[i]); chk("write resp", RESP_OKAY, rsp);
      chk("idle before start", 1'b0, convBusy);
      rdr(ADDR_CLOCK_CTRL); chk("clock reg", ckv[i], {24'h0, rd[7:0]});
      wr(ADDR_STATUS_CTRL, 8'h03);
      wait_flag(); chk("flag set", 1'b1, rd[SC_COMPLETE_BIT]);
      chk("conv span", 1'b1, lastRun > 16 * per[i] && lastRun <= 17 * per[i]);
      rdr(ADDR_RESULT_HIGH);
      if (i != 3) chk("result high", ex[15:8], {24'h0, rd[7:0]});
      rdr(ADDR_RESULT_LOW); chk("result low", ex[7:0], {24'h0, rd[7:0]});
      rdr(ADDR_STATUS_CTRL); chk("flag cleared", 1'b0, rd[SC_COMPLETE_BIT]);
    end
    // port logic around the owned pin
    wr(ADDR_PORT_DIR, 8'hff);
    wr(ADDR_PORT_DATA, 8'hff);
    chk("pin enables", 32'h0f7, pinOe);
    chk("pin outputs", 32'h0f7, pinOut);
    rdr(ADDR_PORT_PINS); chk("pin read", 32'h3f7, rd);
    // high read without low read blocks the next store
    levels[3] = 10'h2d6;
    wr(ADDR_CLOCK_CTRL, 8'h00);
    wr(ADDR_STATUS_CTRL, 8'h03);
    wait_flag();
    rdr(ADDR_RESULT_HIGH);
    levels[3] = 10'h0a5;
    wr(ADDR_STATUS_CTRL, 8'h03);
    repeat (60) @(posedge mclk);
    rdr(ADDR_STATUS_CTRL); chk("blocked flag", 1'b0, rd[SC_COMPLETE_BIT]);
    rdr(ADDR_RESULT_LOW); chk("blocked low", 8'h80, rd[7:0]);
    // continuous runs overwrite unread data until stopped
    wr(ADDR_STATUS_CTRL, 8'h23);
    wait_flag();
    levels[3] = 10'h1e7;
    repeat (40) @(posedge mclk);
    rdr(ADDR_RESULT_HIGH); chk("cont high", 8'h79, rd[7:0]);
    rdr(ADDR_RESULT_LOW); chk("cont low", 8'hc0, rd[7:0]);
    wr(ADDR_STATUS_CTRL, 8'h1f);
    repeat (40) @(posedge mclk);
    chk("stopped", 1'b0, convBusy);
    chk("powered off", 1'b0, analogCtrl.powerOn);
    // writes made while bit 3 was owned never reached its latches
    chk("pins released", 32'h0f7, pinOe);
    chk("outputs released", 32'h0f7, pinOut);
    // interrupt mode, first frozen by the clock enable
    wr(ADDR_STATUS_CTRL, 8'h43);
    clkEn <= 1'b0;
    repeat (30) @(posedge mclk);
    chk("frozen", 1'b0, convIrq);
    clkEn <= 1'b1;
    for (int n = 0; n < 200 && convIrq !== 1'b1; n++) @(posedge mclk);
    chk("irq raised", 1'b1, convIrq);
    rdr(ADDR_STATUS_CTRL); chk("irq status", 8'h43, rd[7:0]);
    rdr(ADDR_RESULT_HIGH);
    rdr(ADDR_RESULT_LOW);
    chk("irq cleared", 1'b0, convIrq);
    close_out();
  end
  // watchdog sized well beyond the longest expected run
  initial begin
    repeat (20000) @(posedge mclk);
    failures++;
    close_out();
  end
endmodule
